// *** core/fpc_top.sv ***
`timescale 1ns/1ps
module fpc_top #(
    parameter int unsigned CNT_W = fpc_pkg::CNT_W,
    parameter int unsigned TIMEOUT_CLKS = fpc_pkg::TIMEOUT_CLKS,
    parameter int unsigned GATE_TICKS = fpc_pkg::GATE_TICKS,
    parameter int unsigned TARGET_CLKS = fpc_pkg::TARGET_CLKS
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic measure_start_in,
    input wire logic frequency_input_pin_in,
    output logic busy_out,
    output logic done_out,
    output logic [CNT_W-1:0] edge_count_out,
    output logic period_valid_out,
    output logic phase_short_out,
    output logic [CNT_W-1:0] period_count_out,
    output logic [CNT_W-1:0] period_clocks_out,
    output logic [fpc_pkg::DIV_W-1:0] mean_period_out,
    output logic [fpc_pkg::DIV_W-1:0] fine_freq_out
);
    localparam int unsigned DW = fpc_pkg::DIV_W;
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
    localparam logic [63:0] GATE_CLKS = 64'(GATE_TICKS) * 64'(fpc_pkg::PRESCALE);
    // Rate limit turned into an edge count for the actual gate, rounded up
    localparam logic [CNT_W-1:0] EDGE_LIMIT = CNT_W'((64'(fpc_pkg::PERIOD_LIMIT_HZ) * GATE_CLKS
        + 64'(fpc_pkg::CLK_HZ) - 64'h1) / 64'(fpc_pkg::CLK_HZ));
    localparam logic [CNT_W-1:0] MIN_PHASE = CNT_W'(fpc_pkg::MIN_PHASE_CLKS);
    localparam logic [CNT_W-1:0] TIMEOUT = CNT_W'(TIMEOUT_CLKS);
    localparam logic [fpc_pkg::DIV_STEP_W-1:0] DIV_LAST = fpc_pkg::DIV_STEP_W'(DW - 1);

    // Refuse clocks or widths the gate and counters cannot serve
    if (fpc_pkg::CLK_HZ > fpc_pkg::CLK_MAX_HZ || CNT_W < 24 || CNT_W > 40)
    begin : g_chk
        $error("Clock rate or counter width out of range");
    end

    fpc_gate_if gate_bus ();

    fpc_gate_timer #(
        .GATE_TICKS(GATE_TICKS)
    ) u_gate (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .gate(gate_bus.timer)
    );

    fpc_pkg::fpc_state_e state_reg, state_next;
    logic run_reg, run_next;
    logic busy_reg, busy_next;
    logic pin_reg, pin_next;
    logic [CNT_W-1:0] edge_reg, edge_next;
    logic [CNT_W-1:0] periods_reg, periods_next;
    logic [CNT_W-1:0] events_reg, events_next;
    logic [CNT_W-1:0] clocks_reg, clocks_next;
    logic [CNT_W-1:0] phase_reg, phase_next;
    logic [CNT_W-1:0] interval_reg, interval_next;
    logic short_reg, short_next;
    logic valid_reg, valid_next;
    logic done_reg, done_next;
    logic sel_reg, sel_next;
    logic [fpc_pkg::DIV_STEP_W-1:0] step_reg, step_next;
    logic [CNT_W:0] rem_reg, rem_next;
    logic [CNT_W-1:0] den_reg, den_next;
    logic [DW-1:0] quo_reg, quo_next;
    logic [DW-1:0] mean_reg, mean_next;
    logic [DW-1:0] fine_reg, fine_next;
    logic fall;
    logic change;
    logic [63:0] prod;
    logic [CNT_W:0] rem_sh;
    logic [DW-1:0] quo_sh;

    // ----------------------------------------------------------------
    // Measurement sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        run_next = run_reg;
        pin_next = frequency_input_pin_in;
        edge_next = edge_reg;
        periods_next = periods_reg;
        events_next = events_reg;
        clocks_next = clocks_reg;
        phase_next = phase_reg;
        interval_next = interval_reg;
        short_next = short_reg;
        valid_next = valid_reg;
        done_next = 1'b0;
        sel_next = sel_reg;
        step_next = step_reg;
        rem_next = rem_reg;
        den_next = den_reg;
        quo_next = quo_reg;
        mean_next = mean_reg;
        fine_next = fine_reg;
        fall = pin_reg && !frequency_input_pin_in;
        change = pin_reg ^ frequency_input_pin_in;
        // Aim the timed interval near the target clock count
        prod = 64'(edge_reg) * 64'(TARGET_CLKS) / GATE_CLKS;
        rem_sh = {rem_reg[CNT_W-1:0], quo_reg[DW-1]};
        quo_sh = {quo_reg[DW-2:0], 1'b0};
        if (rem_sh >= {1'b0, den_reg})
        begin
            rem_sh = rem_sh - {1'b0, den_reg};
            quo_sh[0] = 1'b1;
        end
        case (state_reg)
            fpc_pkg::FPC_IDLE:
            begin
                // Late start requests while busy are ignored, except in the done cycle, whose state is already idle
                if (measure_start_in)
                begin
                    edge_next = '0;
                    clocks_next = '0;
                    short_next = 1'b0;
                    valid_next = 1'b0;
                    run_next = 1'b1;
                    state_next = fpc_pkg::FPC_ARM;
                end
            end
            fpc_pkg::FPC_ARM:
            begin
                if (gate_bus.start_pulse)
                    state_next = fpc_pkg::FPC_GATE;
            end
            fpc_pkg::FPC_GATE:
            begin
                if (gate_bus.stop_pulse)
                begin
                    run_next = 1'b0;
                    periods_next = (prod[CNT_W-1:0] == '0) ? ONE : prod[CNT_W-1:0];
                    clocks_next = '0;
                    if (edge_reg != '0 && edge_reg < EDGE_LIMIT)
                        state_next = fpc_pkg::FPC_PER_ARM;
                    else
                        state_next = fpc_pkg::FPC_DONE;
                end
                else if (fall)
                    edge_next = edge_reg + ONE;
            end
            fpc_pkg::FPC_PER_ARM:
            begin
                // Reuse the clock counter as a wait limit before the first change
                clocks_next = clocks_reg + ONE;
                if (change)
                begin
                    clocks_next = '0;
                    events_next = '0;
                    phase_next = '0;
                    state_next = fpc_pkg::FPC_PER_RUN;
                end
                else if (clocks_reg >= TIMEOUT)
                    state_next = fpc_pkg::FPC_DONE;
            end
            fpc_pkg::FPC_PER_RUN:
            begin
                clocks_next = clocks_reg + ONE;
                phase_next = phase_reg + ONE;
                if (change)
                begin
                    phase_next = '0;
                    events_next = events_reg + ONE;
                    // Too short a phase may lose changes; flag but keep timing
                    if (phase_reg + ONE < MIN_PHASE)
                        short_next = 1'b1;
                    if (events_reg + ONE == {periods_reg[CNT_W-2:0], 1'b0})
                    begin
                        interval_next = clocks_reg + ONE;
                        clocks_next = clocks_reg + ONE;
                        rem_next = '0;
                        den_next = periods_reg;
                        quo_next = DW'({clocks_reg + ONE, fpc_pkg::FRAC_BITS'(0)});
                        step_next = '0;
                        sel_next = 1'b0;
                        state_next = fpc_pkg::FPC_DIV;
                    end
                end
                else if (clocks_reg >= TIMEOUT)
                    state_next = fpc_pkg::FPC_DONE;
            end
            fpc_pkg::FPC_DIV:
            begin
                // One quotient bit per clock keeps the divider small
                rem_next = rem_sh;
                quo_next = quo_sh;
                step_next = step_reg + 1'b1;
                if (step_reg == DIV_LAST)
                begin
                    step_next = '0;
                    rem_next = '0;
                    if (!sel_reg)
                    begin
                        mean_next = quo_sh;
                        sel_next = 1'b1;
                        den_next = interval_reg;
                        quo_next = DW'(64'(fpc_pkg::CLK_HZ) * 64'(fpc_pkg::FREQ_SCALE)
                            * 64'(periods_reg));
                    end
                    else
                    begin
                        fine_next = quo_sh;
                        valid_next = 1'b1;
                        state_next = fpc_pkg::FPC_DONE;
                    end
                end
            end
            fpc_pkg::FPC_DONE:
            begin
                done_next = 1'b1;
                state_next = fpc_pkg::FPC_IDLE;
            end
            default:
            begin
                run_next = 1'b0;
                state_next = fpc_pkg::FPC_IDLE;
            end
        endcase
        // Busy stays up through the done cycle
        busy_next = (state_next != fpc_pkg::FPC_IDLE) || done_next;
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            state_reg <= fpc_pkg::FPC_IDLE;
            run_reg <= 1'b0;
            busy_reg <= 1'b0;
            pin_reg <= 1'b0;
            edge_reg <= '0;
            periods_reg <= '0;
            events_reg <= '0;
            clocks_reg <= '0;
            phase_reg <= '0;
            interval_reg <= '0;
            short_reg <= 1'b0;
            valid_reg <= 1'b0;
            done_reg <= 1'b0;
            sel_reg <= 1'b0;
            step_reg <= '0;
            rem_reg <= '0;
            den_reg <= '0;
            quo_reg <= '0;
            mean_reg <= '0;
            fine_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            run_reg <= run_next;
            busy_reg <= busy_next;
            pin_reg <= pin_next;
            edge_reg <= edge_next;
            periods_reg <= periods_next;
            events_reg <= events_next;
            clocks_reg <= clocks_next;
            phase_reg <= phase_next;
            interval_reg <= interval_next;
            short_reg <= short_next;
            valid_reg <= valid_next;
            done_reg <= done_next;
            sel_reg <= sel_next;
            step_reg <= step_next;
            rem_reg <= rem_next;
            den_reg <= den_next;
            quo_reg <= quo_next;
            mean_reg <= mean_next;
            fine_reg <= fine_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign gate_bus.run = run_reg;
    assign busy_out = busy_reg;
    assign done_out = done_reg;
    assign edge_count_out = edge_reg;
    assign period_valid_out = valid_reg;
    assign phase_short_out = short_reg;
    assign period_count_out = periods_reg;
    assign period_clocks_out = interval_reg;
    assign mean_period_out = mean_reg;
    assign fine_freq_out = fine_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence start_taken;
        state_reg == fpc_pkg::FPC_IDLE && measure_start_in;
    endsequence

    sequence gate_closes;
        state_reg == fpc_pkg::FPC_GATE && gate_bus.stop_pulse;
    endsequence

    clear_on_start_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        start_taken |=> edge_reg == '0 && clocks_reg == '0 && !valid_reg)
        else $error("Counters not cleared at start");

    edge_count_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_reg == fpc_pkg::FPC_GATE && !gate_bus.stop_pulse && fall)
        |=> edge_reg == $past(edge_reg) + ONE)
        else $error("Falling edge in gate not counted");

    gate_order_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        start_taken ##1 (!gate_bus.start_pulse)[*1] |-> state_reg == fpc_pkg::FPC_ARM)
        else $error("Counting began before match B");

    period_after_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_reg == fpc_pkg::FPC_PER_ARM && $past(state_reg) != fpc_pkg::FPC_PER_ARM)
        |-> $past(state_reg) == fpc_pkg::FPC_GATE && edge_reg < EDGE_LIMIT)
        else $error("Period run without a low-rate gated count");

    gate_stops_timer_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        gate_closes |=> !run_reg ##1 !gate_bus.start_pulse)
        else $error("Gate timer still running after stop");

    full_rate_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_reg == fpc_pkg::FPC_PER_RUN)[*2] |-> clocks_reg == $past(clocks_reg) + ONE)
        else $error("Timing counter not at full rate");

    period_stop_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_reg == fpc_pkg::FPC_PER_RUN ##1 state_reg == fpc_pkg::FPC_DIV)
        |-> $past(change) && events_reg == {periods_reg[CNT_W-2:0], 1'b0})
        else $error("Period timing stopped off an event");

    result_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_reg == fpc_pkg::FPC_IDLE && !measure_start_in)
        |=> $stable(edge_reg) && $stable(mean_reg) && $stable(fine_reg))
        else $error("Result changed while idle");

    divide_len_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_reg == fpc_pkg::FPC_PER_RUN ##1 state_reg == fpc_pkg::FPC_DIV)
        |-> ##[111:113] valid_reg)
        else $error("Derived results late");
endmodule

// *** core/fpc_pkg.sv ***
// Contract
// - Count every falling input edge during a gate just under one second; the gate is 39062 ticks, 9999872 clocks.
// - Gate timer is clocked from the system clock divided by 256.
// - Gate timer is 16 bits; one gate fits without wrap up to 16 MHz.
// - Compare match B starts edge counting, compare match A stops it.
// - Start and stop come from match events with equal latency.
// - Period measurement follows a gated count only, when below 25 kHz.
// - Period timing counter runs undivided at the system clock.
// - First pin change starts, last pin change stops, through one shared path.
// - Period count chosen so the timed interval is about ten million clocks.
// - Mean period and a finer frequency are derived from interval and count.
package fpc_pkg;
    // ----------------------------------------------------------------
    // Clock and gate timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_MAX_HZ = 16_000_000;
    localparam int unsigned PRESCALE = 256;
    localparam int unsigned GATE_TIMER_W = 16;
    localparam int unsigned GATE_TIME_MS = 1000;
    // Longest whole tick count that fits in the gate
    localparam int unsigned GATE_TICKS = CLK_HZ / 1000 * GATE_TIME_MS / PRESCALE;
    localparam int unsigned GATE_MATCH_B = 1;
    localparam int unsigned GATE_MATCH_A = GATE_MATCH_B + GATE_TICKS;
    // ----------------------------------------------------------------
    // Period measurement
    // ----------------------------------------------------------------
    localparam int unsigned CNT_W = 32;
    localparam int unsigned PERIOD_LIMIT_HZ = 25_000;
    localparam int unsigned TARGET_CLKS = 10_000_000;
    localparam int unsigned TIMEOUT_CLKS = 2 * TARGET_CLKS;
    localparam int unsigned MIN_PHASE_US = 10;
    localparam int unsigned MIN_PHASE_CLKS = (MIN_PHASE_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned FRAC_BITS = 8;
    localparam int unsigned FREQ_SCALE = 1000;
    localparam int unsigned DIV_W = 56;
    localparam int unsigned DIV_STEP_W = 6;
    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FPC_IDLE,
        FPC_ARM,
        FPC_GATE,
        FPC_PER_ARM,
        FPC_PER_RUN,
        FPC_DIV,
        FPC_DONE
    } fpc_state_e;
endpackage

// *** core/fpc_gate_if.sv ***
`timescale 1ns/1ps
interface fpc_gate_if;
    logic run;
    logic start_pulse;
    logic stop_pulse;
    logic [fpc_pkg::GATE_TIMER_W-1:0] ticks;
    modport timer (input run, output start_pulse, output stop_pulse, output ticks);
    modport ctrl (output run, input start_pulse, input stop_pulse, input ticks);
endinterface

// *** core/fpc_gate_timer.sv ***
`timescale 1ns/1ps
module fpc_gate_timer #(
    parameter int unsigned PRESCALE = fpc_pkg::PRESCALE,
    parameter int unsigned TIMER_W = fpc_pkg::GATE_TIMER_W,
    parameter int unsigned GATE_TICKS = fpc_pkg::GATE_TICKS
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    fpc_gate_if.timer gate
);
    localparam int unsigned PS_W = $clog2(PRESCALE);
    localparam logic [PS_W-1:0] PS_LAST = PS_W'(PRESCALE - 1);
    localparam logic [TIMER_W-1:0] MATCH_B = TIMER_W'(fpc_pkg::GATE_MATCH_B);
    localparam logic [TIMER_W-1:0] MATCH_A = TIMER_W'(fpc_pkg::GATE_MATCH_B + GATE_TICKS);
    localparam int unsigned GATE_CLKS = GATE_TICKS * PRESCALE;

    // Refuse a gate that would wrap the timer
    if (fpc_pkg::GATE_MATCH_B + GATE_TICKS >= (1 << TIMER_W) || PRESCALE < 2 || GATE_TICKS < 1)
    begin : g_chk
        $error("Gate timer too narrow for the gate");
    end

    logic [PS_W-1:0] ps_reg, ps_next;
    logic [TIMER_W-1:0] tmr_reg, tmr_next;
    logic start_reg, start_next;
    logic stop_reg, stop_next;
    logic tick;

    // ----------------------------------------------------------------
    // Prescaler and compare matches
    // ----------------------------------------------------------------
    // Both matches are registered once, so start and stop share latency
    always_comb
    begin
        tick = gate.run && (ps_reg == PS_LAST);
        ps_next = '0;
        tmr_next = '0;
        start_next = 1'b0;
        stop_next = 1'b0;
        if (gate.run)
        begin
            ps_next = tick ? '0 : ps_reg + 1'b1;
            tmr_next = tick ? tmr_reg + 1'b1 : tmr_reg;
            start_next = tick && (tmr_reg + 1'b1 == MATCH_B);
            stop_next = tick && (tmr_reg + 1'b1 == MATCH_A);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            ps_reg <= '0;
            tmr_reg <= '0;
            start_reg <= 1'b0;
            stop_reg <= 1'b0;
        end
        else
        begin
            ps_reg <= ps_next;
            tmr_reg <= tmr_next;
            start_reg <= start_next;
            stop_reg <= stop_next;
        end
    end

    assign gate.start_pulse = start_reg;
    assign gate.stop_pulse = stop_reg;
    assign gate.ticks = tmr_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [31:0] gap_reg;
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in || start_reg)
            gap_reg <= 32'h0000_0001;
        else
            gap_reg <= gap_reg + 32'h0000_0001;
    end

    gate_length_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        stop_reg |-> gap_reg == GATE_CLKS)
        else $error("Gate length is not the nominal count");

    tick_spacing_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (gate.run && ps_reg == PS_LAST && $past(gate.run)) |-> $past(ps_reg) == PS_LAST - 1'b1)
        else $error("Prescaler does not divide evenly");
endmodule

// *** verif/fpc_src_model.sv ***
`timescale 1ns/1ps
// Square-wave source standing in for the signal being measured
module fpc_src_model (
    input wire logic clk_in,
    input wire logic run_in,
    input wire logic [15:0] half_in,
    output logic wave_out
);
    logic [15:0] cnt_reg;

    // ----------------------------------------------------------------
    // Wave generation
    // ----------------------------------------------------------------
    initial
    begin
        wave_out = 1'b1;
        cnt_reg = 16'h0000;
    end

    // Edges land on the falling clock edge, clear of the sampling edge
    always @(negedge clk_in)
    begin
        if (!run_in)
        begin
            cnt_reg <= 16'h0000; // Line rests at its last level while stopped
        end
        else if (cnt_reg >= half_in - 16'h0001) // Safe when the half period shrinks
        begin
            cnt_reg <= 16'h0000;
            wave_out <= ~wave_out;
        end
        else
        begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule

// *** verif/frequency_period_counter_tb_top.sv ***
`timescale 1ns/1ps
module frequency_period_counter_tb_top;
    logic clk_in;
    logic sys_rst_in;
    logic measure_start_in;
    logic src_run;
    logic [15:0] src_half;
    logic src_wave;
    logic busy_out;
    logic done_out;
    logic [31:0] edge_count_out;
    logic period_valid_out;
    logic phase_short_out;
    logic [31:0] period_count_out;
    logic [31:0] period_clocks_out;
    logic [55:0] mean_period_out;
    logic [55:0] fine_freq_out;
    int error_cnt;
    int comparisons;
    int elapsed;

    // ----------------------------------------------------------------
    // Clock, design and source
    // ----------------------------------------------------------------
    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // Short gate keeps the run small; edge counts and target scale with it
    fpc_top #(
        .TIMEOUT_CLKS(30000),
        .GATE_TICKS(40),
        .TARGET_CLKS(10240)
    ) i_fpc_top (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .measure_start_in(measure_start_in),
        .frequency_input_pin_in(src_wave),
        .busy_out(busy_out),
        .done_out(done_out),
        .edge_count_out(edge_count_out),
        .period_valid_out(period_valid_out),
        .phase_short_out(phase_short_out),
        .period_count_out(period_count_out),
        .period_clocks_out(period_clocks_out),
        .mean_period_out(mean_period_out),
        .fine_freq_out(fine_freq_out)
    );

    fpc_src_model i_fpc_src_model (
        .clk_in(clk_in),
        .run_in(src_run),
        .half_in(src_half),
        .wave_out(src_wave)
    );

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (error_cnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Start pulse, then confirm the cleared count one cycle later
    task automatic start_measure();
        @(negedge clk_in);
        measure_start_in = 1'b1;
        @(negedge clk_in);
        measure_start_in = 1'b0;
        elapsed = 1;
        check("busy after start", busy_out, 1'b1);
        check("edge count cleared", edge_count_out, 32'h0);
    endtask

    // Bounded wait; done is a single-cycle pulse with busy still up
    task automatic wait_done(input int limit);
        while (done_out !== 1'b1 && elapsed < limit)
        begin
            @(negedge clk_in);
            elapsed++;
        end
        check("done seen", done_out, 1'b1);
        check("busy in done cycle", busy_out, 1'b1);
        @(negedge clk_in);
        check("done pulse width", done_out, 1'b0);
        check("busy after done", busy_out, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values();
        check("busy at reset", busy_out, 1'b0);
        check("done at reset", done_out, 1'b0);
        check("valid at reset", period_valid_out, 1'b0);
        check("edges at reset", edge_count_out, 32'h0);
        check("clocks at reset", period_clocks_out, 32'h0);
    endtask

    // 10 kHz: gated count, then period run, a refused start mid-gate
    task automatic t_low_freq();
        logic [31:0] edges;
        logic [63:0] held;
        src_half = 16'd500;
        src_run = 1'b1;
        start_measure();
        repeat (5_000) @(negedge clk_in);
        elapsed += 5_000;
        measure_start_in = 1'b1; // Ignored while busy
        @(negedge clk_in);
        measure_start_in = 1'b0;
        elapsed++;
        wait_done(25_000);
        edges = edge_count_out;
        // Gate of 10240 clocks plus a period run of edges*1000 clocks
        check("total time", elapsed > 10_240 + edges * 1000 && elapsed < 11_300 + edges * 1000,
            1'b1);
        check("edges 10k", edges == 32'd10 || edges == 32'd11, 1'b1);
        check("period valid", period_valid_out, 1'b1);
        check("period count", period_count_out, edges);
        check("period clocks", period_clocks_out, edges * 32'd1000);
        check("mean period", mean_period_out, 56'h3e800);
        check("fine freq", fine_freq_out, 56'h989680);
        check("phase short", phase_short_out, 1'b0);
        held = {period_clocks_out, edge_count_out};
        repeat (200) @(negedge clk_in);
        check("results held", {period_clocks_out, edge_count_out}, held);
        check("valid held", period_valid_out, 1'b1);
    endtask

    // 50 kHz: above the limit, so no period run follows
    task automatic t_high_freq();
        logic [31:0] edges;
        src_half = 16'd100;
        start_measure();
        check("valid cleared", period_valid_out, 1'b0);
        wait_done(12_000);
        edges = edge_count_out;
        check("edges 50k", edges == 32'd51 || edges == 32'd52, 1'b1);
        check("no period run", period_valid_out, 1'b0);
        check("gate only time", elapsed < 10_800, 1'b1);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        error_cnt = 0;
        comparisons = 0;
        elapsed = 0;
        sys_rst_in = 1'b1;
        measure_start_in = 1'b0;
        src_run = 1'b0;
        src_half = 16'd500;
        repeat (10) @(negedge clk_in);
        t_reset_values();
        sys_rst_in = 1'b0;
        t_low_freq();
        t_high_freq();
        close_out();
    end

    // Both measurements need about thirty-two thousand clocks together
    initial
    begin
        repeat (100_000) @(posedge clk_in);
        error_cnt++;
        close_out();
    end
endmodule
